// ==== rtl/rtc_alarm_status_irq.v ====
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "rtc_alarm_status_irq_consts.vh"

module rtc_alarm_status_irq (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // bcd counters of the clock core
  input wire second_tick,
  input wire twelve_hour_mode,
  input wire [6:0] cur_sec,
  input wire [6:0] cur_min,
  input wire [5:0] cur_hour,
  input wire cur_pm,
  input wire [2:0] cur_day,
  input wire [5:0] cur_date,
  input wire [4:0] cur_month,
  // time alarm fields
  input wire [6:0] alarm_sec,
  input wire alarm_sec_en,
  input wire [6:0] alarm_min,
  input wire alarm_min_en,
  input wire [5:0] alarm_hour,
  input wire alarm_pm,
  input wire alarm_hour_en,
  // entry checks: time, calendar, time alarm
  input wire [2:0] entry_programmed,
  input wire [2:0] entry_bad,
  // to the clock core and interrupt controller
  output reg time_update_request,
  output reg calendar_update_request,
  output reg irq
);

  // ****************
  // operating notes, bus side
  // ****************
  // single word transfers only
  // hsize not decoded, byte lanes ignored
  // no wait states, hreadyout held high
  // response always okay, never an error
  // address decoded over all 32 bits
  // unmapped reads return zero
  // writes to read-only words dropped
  // write-only words read back as zero
  // write lands at end of its data phase
  // read data loaded at address phase
  // read data held until the next read
  // back to back transfers accepted
  // data phase write needs no extra cycle

  // ****************
  // operating notes, status flags
  // ****************
  // five sticky flags, bits 0 to 4
  // acknowledge, alarm, second, time, calendar
  // each set by a one-cycle source pulse
  // each cleared by a one in the clear word
  // a zero in the clear word leaves it alone
  // set beats clear in the same cycle
  // so no event is ever lost to software
  // software must clear, then re-read
  // a flag seen set after clear is a new event

  // ****************
  // operating notes, interrupt mask
  // ****************
  // one mask bit per status flag
  // set word turns bits on, zeros ignored
  // clear word turns bits off, zeros ignored
  // set and clear live at different words
  // so they can never land in one cycle
  // mask reads back at its own word
  // mask clears on reset, all sources off
  // irq is the or of flag and mask pairs
  // irq registered, one cycle behind
  // irq is a level, not a pulse

  // ****************
  // operating notes, alarm compare
  // ****************
  // time fields come from the clock core
  // date and month fields held here
  // every enabled field must match at once
  // disabled fields take no part
  // no field enabled means no alarm at all
  // flag set on the rising edge of a match
  // a lasting match sets the flag once
  // hour compare includes the pm bit
  // month enable at bit 23
  // date enable at bit 31

  // ****************
  // operating notes, periodic events
  // ****************
  // counters compared with last cycle
  // minute event on any minute change
  // hour event on any hour change
  // midnight and noon at seconds roll to 00
  // with minutes at 00 and hour matching
  // 24 hour coding: 00 and 12
  // 12 hour coding: 12 am and 12 pm
  // week event on day 1 at midnight
  // month event on date 01 at midnight
  // year event on 01 january at midnight
  // calendar select 3 gives no event

  // ****************
  // operating notes, update handshake
  // ****************
  // control bits 0 and 1 ask for a stop
  // both copied out to the clock core
  // acknowledge flag set on the rising request
  // flag one cycle after the control write
  // software waits for it before reloading
  // dropping both bits lets counting resume
  // acknowledge stays set until cleared
  // hazard: no check that counters really stopped
  // the core must honour the request itself

  // ****************
  // operating notes, entry validity
  // ****************
  // four sticky bits, one per entry word
  // time, calendar and time alarm from core
  // calendar alarm judged here on write
  // month must be bcd 01 to 12
  // date must be bcd 01 to 31
  // checked even with both enables off
  // a good rewrite clears the bit
  // a bad rewrite keeps it set
  // bit left alone while not reprogrammed
  // validity clears on reset

  // ****************
  // operating notes, reset and hazards
  // ****************
  // reset asynchronous, active low
  // all outputs come from flip-flops
  // calendar alarm resets to 01 january
  // control and status reset to zero
  // edge history resets to counter idle
  // so no false event follows reset while the counters read 00
  // counter inputs taken as synchronous
  // a glitch on a counter is an event
  // the core must present settled values
  // second tick must be one cycle wide
  // a wide tick sets the flag each cycle
  // harmless, since the flag is sticky
  // clear then needs the tick to be low
  // irq follows a clear one cycle later
  // software sees irq drop after its write

  // ****************
  // state
  // ****************
  reg [31:0] control_reg;
  reg [31:0] cal_alarm_reg;
  reg [4:0] status_reg;
  reg [4:0] mask_reg;
  reg [3:0] validity_reg;
  reg wr_pend_reg;
  reg [31:0] wr_addr_reg;
  reg [6:0] prev_sec_reg;
  reg [6:0] prev_min_reg;
  reg [5:0] prev_hour_reg;
  reg prev_match_reg;
  reg prev_upd_reg;
  reg [31:0] rdata_next;

  // ****************
  // bus decode
  // ****************
  wire phase_ok = hsel & hready & (htrans == `HTRANS_NONSEQ | htrans == `HTRANS_SEQ);
  wire wr_ctrl = wr_pend_reg & (wr_addr_reg == `OFS_CONTROL);
  wire wr_cala = wr_pend_reg & (wr_addr_reg == `OFS_CAL_ALARM);
  wire wr_sclr = wr_pend_reg & (wr_addr_reg == `OFS_STATUS_CLEAR);
  wire wr_ien = wr_pend_reg & (wr_addr_reg == `OFS_IRQ_ENABLE_SET);
  wire wr_idis = wr_pend_reg & (wr_addr_reg == `OFS_IRQ_ENABLE_CLEAR);

  // ****************
  // control fields
  // ****************
  wire [1:0] time_event_select = control_reg[`CTRL_TSEL_HI:`CTRL_TSEL_LO];
  wire [1:0] calendar_event_select = control_reg[`CTRL_CSEL_HI:`CTRL_CSEL_LO];
  wire upd_any = control_reg[`CTRL_UPD_TIME] | control_reg[`CTRL_UPD_CAL];

  // ****************
  // calendar alarm fields
  // ****************
  wire [4:0] month_alarm = cal_alarm_reg[`CALA_MONTH_HI:`CALA_MONTH_LO];
  wire month_alarm_enable = cal_alarm_reg[`CALA_MONTH_EN];
  wire [5:0] day_of_month_alarm = cal_alarm_reg[`CALA_DATE_HI:`CALA_DATE_LO];
  wire day_of_month_alarm_enable = cal_alarm_reg[`CALA_DATE_EN];

  // alarm compare over every enabled field
  wire any_en = alarm_sec_en | alarm_min_en | alarm_hour_en | month_alarm_enable
    | day_of_month_alarm_enable;
  wire alarm_match = any_en
    & (~alarm_sec_en | (alarm_sec == cur_sec))
    & (~alarm_min_en | (alarm_min == cur_min))
    & (~alarm_hour_en | ((alarm_hour == cur_hour) & (alarm_pm == cur_pm)))
    & (~month_alarm_enable | (month_alarm == cur_month))
    & (~day_of_month_alarm_enable | (day_of_month_alarm == cur_date));

  // ****************
  // time and calendar events
  // ****************
  wire sec_changed = cur_sec != prev_sec_reg;
  wire min_changed = cur_min != prev_min_reg;
  wire hour_changed = cur_hour != prev_hour_reg;
  wire top_of_hour = sec_changed & (cur_sec == `BCD_ZERO7) & (cur_min == `BCD_ZERO7);
  // midnight and noon depend on 12 or 24 hour coding
  wire is_midnight = twelve_hour_mode ? ((cur_hour == `BCD_TWELVE) & ~cur_pm)
    : (cur_hour == `BCD_ZERO6);
  wire is_noon = twelve_hour_mode ? ((cur_hour == `BCD_TWELVE) & cur_pm)
    : (cur_hour == `BCD_TWELVE);
  wire day_start = top_of_hour & is_midnight;
  reg time_event;
  reg cal_event;

  // time event selection
  always @* begin
    case (time_event_select)
      `TSEL_MINUTE: time_event = min_changed;
      `TSEL_HOUR: time_event = hour_changed;
      `TSEL_MIDNIGHT: time_event = day_start;
      `TSEL_NOON: time_event = top_of_hour & is_noon;
      default: time_event = 1'b0;
    endcase
  end

  // calendar event selection, value 3 gives none
  always @* begin
    case (calendar_event_select)
      `CSEL_WEEK: cal_event = day_start & (cur_day == `DAY_MONDAY);
      `CSEL_MONTH: cal_event = day_start & (cur_date == `BCD_FIRST6);
      `CSEL_YEAR: cal_event = day_start & (cur_date == `BCD_FIRST6)
        & (cur_month == `BCD_FIRST5);
      default: cal_event = 1'b0;
    endcase
  end

  // ****************
  // flag sources
  // ****************
  wire [4:0] flag_set;
  assign flag_set[`FLAG_ACK] = upd_any & ~prev_upd_reg;
  assign flag_set[`FLAG_ALARM] = alarm_match & ~prev_match_reg;
  assign flag_set[`FLAG_SECOND] = second_tick;
  assign flag_set[`FLAG_TIME] = time_event;
  assign flag_set[`FLAG_CAL] = cal_event;

  // ****************
  // per-flag status and mask bits
  // ****************
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_FLAGS; gi = gi + 1) begin : g_flag
      // sticky flag, set wins over a clear in the same cycle
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          status_reg[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          status_reg[gi] <= 1'b1;
        end else if (wr_sclr & hwdata[gi]) begin
          status_reg[gi] <= 1'b0;
        end
      end
      // mask bit driven by set and clear registers
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mask_reg[gi] <= 1'b0;
        end else if (wr_ien & hwdata[gi]) begin
          mask_reg[gi] <= 1'b1;
        end else if (wr_idis & hwdata[gi]) begin
          mask_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************
  // calendar alarm entry check
  // ****************
  wire [4:0] new_month = hwdata[`CALA_MONTH_HI:`CALA_MONTH_LO];
  wire [5:0] new_date = hwdata[`CALA_DATE_HI:`CALA_DATE_LO];
  wire cala_bad = (new_month[3:0] > `BCD_UNIT_MAX) | (new_month > `MONTH_MAX)
    | (new_month == `BCD_ZERO5) | (new_date[3:0] > `BCD_UNIT_MAX)
    | (new_date > `DATE_MAX) | (new_date == `BCD_ZERO6);
  wire [3:0] prog_vec = {wr_cala, entry_programmed};
  wire [3:0] bad_vec = {cala_bad, entry_bad};

  // ****************
  // registers written by software
  // ****************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_reg <= `CTRL_RESET;
      cal_alarm_reg <= `CALA_RESET;
      validity_reg <= `VALID_RESET;
    end else begin
      if (wr_ctrl) begin
        control_reg <= hwdata;
      end
      if (wr_cala) begin
        cal_alarm_reg <= hwdata & `CALA_WRITE_MASK;
      end
      // reprogramming a register re-judges its flag
      validity_reg <= (validity_reg & ~prog_vec) | (prog_vec & bad_vec);
    end
  end

  // ****************
  // history for edge detection
  // ****************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_sec_reg <= `BCD_ZERO7;
      prev_min_reg <= `BCD_ZERO7;
      prev_hour_reg <= `BCD_ZERO6;
      prev_match_reg <= 1'b0;
      prev_upd_reg <= 1'b0;
    end else begin
      prev_sec_reg <= cur_sec;
      prev_min_reg <= cur_min;
      prev_hour_reg <= cur_hour;
      prev_match_reg <= alarm_match;
      prev_upd_reg <= upd_any;
    end
  end

  // ****************
  // read mux, unmapped reads as zero
  // ****************
  always @* begin
    rdata_next = 32'h00000000;
    case (haddr)
      `OFS_CONTROL: rdata_next = control_reg;
      `OFS_CAL_ALARM: rdata_next = cal_alarm_reg;
      `OFS_STATUS: rdata_next = {27'h0000000, status_reg};
      `OFS_IRQ_MASK: rdata_next = {27'h0000000, mask_reg};
      `OFS_VALIDITY: rdata_next = {28'h0000000, validity_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // ****************
  // bus phases and outputs
  // ****************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h00000000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
      time_update_request <= 1'b0;
      calendar_update_request <= 1'b0;
    end else begin
      wr_pend_reg <= phase_ok & hwrite;
      if (phase_ok) begin
        wr_addr_reg <= haddr;
      end
      if (phase_ok & ~hwrite) begin
        hrdata <= rdata_next;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= |(status_reg & mask_reg);
      time_update_request <= control_reg[`CTRL_UPD_TIME];
      calendar_update_request <= control_reg[`CTRL_UPD_CAL];
    end
  end

endmodule

// ==== rtl/rtc_alarm_status_irq_consts.vh ====
`ifndef RTC_ALARM_STATUS_IRQ_CONSTS_VH
`define RTC_ALARM_STATUS_IRQ_CONSTS_VH

// ****************
// register offsets
// ****************
`define OFS_CONTROL 32'h0ffffeb0
`define OFS_CAL_ALARM 32'h0ffffec4
`define OFS_STATUS 32'h0ffffec8
`define OFS_STATUS_CLEAR 32'h0ffffecc
`define OFS_IRQ_ENABLE_SET 32'h0ffffed0
`define OFS_IRQ_ENABLE_CLEAR 32'hfffffed4
`define OFS_IRQ_MASK 32'h0ffffed8
`define OFS_VALIDITY 32'h0ffffedc

// ****************
// field layout
// ****************
`define NUM_FLAGS 5
`define NUM_VALID 4
`define FLAG_ACK 0
`define FLAG_ALARM 1
`define FLAG_SECOND 2
`define FLAG_TIME 3
`define FLAG_CAL 4
`define VALID_CAL_ALARM 3
`define CTRL_UPD_TIME 0
`define CTRL_UPD_CAL 1
`define CTRL_TSEL_LO 8
`define CTRL_TSEL_HI 9
`define CTRL_CSEL_LO 16
`define CTRL_CSEL_HI 17
`define CALA_MONTH_LO 16
`define CALA_MONTH_HI 20
`define CALA_MONTH_EN 23
`define CALA_DATE_LO 24
`define CALA_DATE_HI 29
`define CALA_DATE_EN 31
`define CALA_WRITE_MASK 32'hbf9f0000
`define CALA_RESET 32'h01010000

// ****************
// encodings and BCD limits
// ****************
`define TSEL_MINUTE 2'h0
`define TSEL_HOUR 2'h1
`define TSEL_MIDNIGHT 2'h2
`define TSEL_NOON 2'h3
`define CSEL_WEEK 2'h0
`define CSEL_MONTH 2'h1
`define CSEL_YEAR 2'h2
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define BCD_ZERO7 7'h00
`define BCD_ZERO6 6'h00
`define BCD_ZERO5 5'h00
`define CTRL_RESET 32'h00000000
`define VALID_RESET 4'h0
`define BCD_TWELVE 6'h12
`define BCD_FIRST6 6'h01
`define BCD_FIRST5 5'h01
`define DAY_MONDAY 3'h1
`define MONTH_MAX 5'h12
`define DATE_MAX 6'h31
`define BCD_UNIT_MAX 4'h9

`endif

// ==== testbench/rtc_alarm_status_irq_chk.sv ====
`timescale 1ns/1ps
`include "rtc_alarm_status_irq_consts.vh"
module rtc_alarm_status_irq_chk (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // events and interrupt
  input wire second_tick,
  input wire irq
);
  reg wr_ph;
  reg [31:0] wa;
  reg [4:0] msk;
  wire take = hsel && hready && htrans[1];
  wire rd_take = take && !hwrite;
  // ****************
  // shadow of write data phase and mask
  // ****************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      wa <= 32'h0;
      msk <= 5'h0;
    end else begin
      wr_ph <= take && hwrite;
      wa <= haddr;
      if (wr_ph && wa == `OFS_IRQ_ENABLE_SET) begin
        msk <= msk | hwdata[4:0];
      end else if (wr_ph && wa == `OFS_IRQ_ENABLE_CLEAR) begin
        msk <= msk & ~hwdata[4:0];
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // properties
  // ****************
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer");
  read_hold_a: assert property (!rd_take |=> $stable(hrdata)) else $error("hrdata moved");
  wo_read_a: assert property (rd_take && (haddr == `OFS_STATUS_CLEAR ||
    haddr == `OFS_IRQ_ENABLE_SET) |=> hrdata == 32'h0) else $error("write-only read");
  mask_read_a: assert property (rd_take && haddr == `OFS_IRQ_MASK
    |=> hrdata == {27'h0, $past(msk)}) else $error("mask read");
  irq_cause_a: assert property (irq |-> $past(msk) != 5'h0) else $error("irq unmasked");
  irq_drop_a: assert property (wr_ph && wa == `OFS_IRQ_ENABLE_CLEAR &&
    hwdata[4:0] == 5'h1f |-> ##2 !irq) else $error("irq after disable");
  tick_irq_a: assert property (second_tick && msk[2] && !wr_ph |-> ##2 irq)
    else $error("tick irq");
  irq_sticky_a: assert property (irq && !$past(wr_ph) |=> irq) else $error("irq lost");
  cover property (second_tick && msk[2]);
  cover property (rd_take && haddr == `OFS_IRQ_MASK);
  cover property ($fell(irq));
endmodule
bind rtc_alarm_status_irq rtc_alarm_status_irq_chk chk (.*);

// ==== testbench/rtc_alarm_status_irq_test.sv ====
`timescale 1ns/1ps
`include "rtc_alarm_status_irq_consts.vh"
module rtc_alarm_status_irq_test;
  // ****************
  // signals
  // ****************
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, second_tick = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, cur_day = 3'h1, entry_programmed = 0, entry_bad = 0;
  logic hreadyout, hresp, time_update_request, calendar_update_request, irq;
  logic twelve_hour_mode = 0, cur_pm = 0, alarm_pm = 0;
  logic alarm_sec_en = 0, alarm_min_en = 0, alarm_hour_en = 0;
  logic [6:0] cur_sec = 0, cur_min = 0, alarm_sec = 0, alarm_min = 0;
  logic [5:0] cur_hour = 0, cur_date = 6'h01, alarm_hour = 0;
  logic [4:0] cur_month = 5'h01, m = 0, v;
  logic [5:0] hb[4] = '{6'h05, 6'h05, 6'h23, 6'h11};
  logic [5:0] ha[4] = '{6'h06, 6'h06, 6'h00, 6'h12};
  logic [13:0] cb[3] = '{{3'h7, 6'h15, 5'h05}, {3'h2, 6'h31, 5'h05}, {3'h2, 6'h31, 5'h12}};
  logic [13:0] ca[3] = '{{3'h1, 6'h16, 5'h05}, {3'h3, 6'h01, 5'h06}, {3'h3, 6'h01, 5'h01}};
  localparam logic [13:0] TUE = {3'h2, 6'h10, 5'h02};
  wire hready = hreadyout;
  int failures = 0, comparisons = 0, cycles = 0;
  rtc_alarm_status_irq DUT (.*);
  // clock and timeout
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop;
    end
  end
  // ****************
  // tasks
  // ****************
  task report_and_stop;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic [4:0] mask_after(input [4:0] cur, input [4:0] set, input [4:0] clr);
    mask_after = (cur | set) & ~clr;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input [31:0] a, input w, input [31:0] d);
    {hsel, htrans, hwrite} <= {1'b1, `HTRANS_NONSEQ, w};
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task rd(input [31:0] a, input [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(r, exp);
  endtask
  task set_t(input [6:0] s, input [6:0] mi, input [5:0] h, input [13:0] c);
    {cur_sec, cur_min, cur_hour} <= {s, mi, h};
    {cur_day, cur_date, cur_month} <= c;
    repeat (2) @(posedge hclk);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(32'h69881928));
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    rd(`OFS_CAL_ALARM, 32'h01010000);
    rd(`OFS_VALIDITY, 0);
    rd(`OFS_IRQ_ENABLE_CLEAR, 0);
    rd(32'h0ffffee0, 0);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      xfer(`OFS_IRQ_ENABLE_SET, 1, v);
      m = mask_after(m, v, 5'h0);
      v = $urandom;
      xfer(`OFS_IRQ_ENABLE_CLEAR, 1, v);
      m = mask_after(m, 5'h0, v);
      rd(`OFS_IRQ_MASK, m);
    end
    xfer(`OFS_IRQ_ENABLE_CLEAR, 1, 32'h1f);
    // second ticks with interrupt
    xfer(`OFS_IRQ_ENABLE_SET, 1, 32'h4);
    second_tick <= 1;
    repeat (2) @(posedge hclk);
    second_tick <= 0;
    rd(`OFS_STATUS, 32'h4);
    xfer(`OFS_STATUS_CLEAR, 1, 32'h1b);
    rd(`OFS_STATUS, 32'h4);
    chk(irq, 1);
    xfer(`OFS_STATUS_CLEAR, 1, 32'h4);
    rd(`OFS_STATUS, 0);
    chk(irq, 0);
    xfer(`OFS_CONTROL, 1, 1);
    @(posedge hclk);
    rd(`OFS_STATUS, 1);
    chk(time_update_request, 1);
    chk(calendar_update_request, 0);
    // time event selects
    for (int s = 0; s < 4; s++) begin
      xfer(`OFS_CONTROL, 1, s << 8);
      set_t(7'h59, 7'h30, 6'h05, TUE);
      xfer(`OFS_STATUS_CLEAR, 1, 32'h1f);
      set_t(0, 7'h31, 6'h05, TUE);
      rd(`OFS_STATUS, (s == 0) ? 32'h8 : 32'h0);
      set_t(7'h59, 7'h59, hb[s], TUE);
      xfer(`OFS_STATUS_CLEAR, 1, 32'h1f);
      set_t(0, 0, ha[s], TUE);
      rd(`OFS_STATUS, 32'h8);
    end
    // noon in 12 hour coding
    twelve_hour_mode <= 1;
    xfer(`OFS_CONTROL, 1, 32'h300);
    set_t(7'h59, 7'h59, 6'h11, TUE);
    xfer(`OFS_STATUS_CLEAR, 1, 32'h1f);
    cur_pm <= 1;
    set_t(0, 0, 6'h12, TUE);
    rd(`OFS_STATUS, 32'h8);
    twelve_hour_mode <= 0;
    cur_pm <= 0;
    // calendar event selects
    for (int s = 0; s < 3; s++) begin
      xfer(`OFS_CONTROL, 1, s << 16);
      set_t(7'h59, 7'h59, 6'h23, cb[s]);
      xfer(`OFS_STATUS_CLEAR, 1, 32'h1f);
      set_t(0, 0, 0, ca[s]);
      rd(`OFS_STATUS, 32'h18);
    end
    // alarm matching
    {alarm_sec_en, alarm_min_en, alarm_hour_en} <= 3'h7;
    xfer(`OFS_CAL_ALARM, 1, 32'h96850000);
    xfer(`OFS_STATUS_CLEAR, 1, 32'h1f);
    set_t(0, 0, 0, {3'h3, 6'h16, 5'h05});
    rd(`OFS_STATUS, 32'h2);
    alarm_hour <= 6'h07;
    set_t(0, 0, 0, {3'h3, 6'h17, 5'h05});
    xfer(`OFS_STATUS_CLEAR, 1, 32'h1f);
    set_t(0, 0, 0, {3'h3, 6'h16, 5'h05});
    rd(`OFS_STATUS, 0);
    xfer(`OFS_CAL_ALARM, 1, 32'h96050000);
    set_t(0, 0, 0, {3'h3, 6'h16, 5'h06});
    alarm_hour <= 0;
    repeat (2) @(posedge hclk);
    rd(`OFS_STATUS, 32'h2);
    // entry validity
    entry_programmed <= 3'h5;
    entry_bad <= 3'h1;
    @(posedge hclk);
    entry_programmed <= 0;
    entry_bad <= 0;
    xfer(`OFS_CAL_ALARM, 1, 32'h13130000);
    rd(`OFS_VALIDITY, 32'h9);
    xfer(`OFS_CAL_ALARM, 1, 32'h01010000);
    rd(`OFS_VALIDITY, 32'h1);
    report_and_stop;
  end
endmodule
